// ===== gphy_pkg.sv
// types shared by the gigabit phy port modules
// assumes gphy_port_map.svh for all numeric constants
package gphy_pkg;
  typedef enum logic {CAL_BUSY, CAL_DONE} cal_state_t;
  typedef logic [2:0] tx_phase_t;
  typedef logic [2:0] tap_sel_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;
endpackage

// ===== gphy_port.sv
// gigabit phy port: byte-wide or reduced ddr pins, forwarded tx clock, rx capture
// assumes sys_clk 200 MHz; phy rx clock and async pins are sampled, not used as clocks
// Contract
// - all transmit logic and the user tx stream run on one reference clock.
// - byte-wide tx data and control leave from output flip-flops.
// - forwarded tx clock comes from a register aligned with the data.
// - byte-wide forwarded clock is the inverse of the tx reference.
// - collision and carrier sense are treated as asynchronous and synchronised.
// - sampled phy rx clock edges time all receive capture; the user rx port runs on sys_clk.
// - byte-wide rx inputs sampled at rx clock edge with adjustable delay.
// - reduced tx data and control driven from double-rate output registers.
// - with output delay, forwarded reduced clock lags data by one 5 ns sys_clk cycle.
// - without output delay, forwarded reduced clock comes from quadrature reference.
// - quadrature reference drives only the forwarded clock, never data.
// - reduced rx inputs sampled on rx clock edges with tunable delay.
// - tx reference may be shared; each instance keeps its own rx clock.
// - one delay calibration controller per instance, used only with shared logic.
`timescale 1ns/10ps
`include "gphy_port_map.svh"
module gphy_port #(parameter bit SHARED_LOGIC = 1'b1) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              mode_reduced,
  input  wire logic              has_out_delay,
  input  wire gphy_pkg::tap_sel_t rx_delay_taps,
  input  wire logic              ext_delay_ready,
  input  wire gphy_pkg::byte_t   tx_data,
  input  wire logic              tx_err,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output gphy_pkg::byte_t        rx_data,
  output logic                   rx_valid,
  output logic                   rx_err,
  output logic                   col_sync,
  output logic                   crs_sync,
  output logic                   delay_ready,
  output gphy_pkg::byte_t        phy_txd,
  output logic                   phy_tx_en,
  output logic                   phy_tx_er,
  output logic                   phy_tx_clk,
  input  wire gphy_pkg::byte_t   phy_rxd,
  input  wire logic              phy_rx_dv,
  input  wire logic              phy_rx_er,
  input  wire logic              phy_rx_clk,
  input  wire logic              phy_col,
  input  wire logic              phy_crs
);
  import gphy_pkg::*;

  stream_if #(.WIDTH(`TX_WORD_W)) in_if ();
  stream_if #(.WIDTH(`TX_WORD_W)) out_if ();

  // tx reference phase and its quadrature copy
  tx_phase_t                phase_reg, phase_next, phase_shift;
  logic                     tx_ref, tx_ref_q;
  logic [`OUT_DELAY_CYC-1:0] ref_line_reg, ref_line_next;
  logic [`OUT_DELAY_CYC:0]  ref_cat;
  logic [`TX_WORD_W-1:0]    tx_word_reg, tx_word_next;
  logic                     tx_act_reg, tx_act_next;
  byte_t                    txd_next;
  logic                     tx_en_next, tx_er_next, tx_clk_next;

  // rx capture state
  logic [`SYNC_W-1:0] sy;
  logic               rx_clk_prev_reg;
  logic               rx_rise, rx_fall, rise_dly, fall_dly;
  logic [`TAP_N-1:0]  rise_line_reg, rise_line_next, fall_line_reg, fall_line_next;
  byte_t              rx_data_reg, rx_data_next;
  logic               rx_valid_reg, rx_valid_next, rx_err_reg, rx_err_next;
  nibble_t            lo_nib_reg, lo_nib_next;
  logic               lo_ctl_reg, lo_ctl_next;

  // calibration controller
  cal_state_t           cal_state_reg, cal_state_next;
  logic [`CAL_CNT_W-1:0] cal_cnt_reg, cal_cnt_next;

  assign in_if.data  = {tx_err, tx_data};
  assign in_if.valid = tx_valid;
  assign tx_ready    = in_if.ready;

  word_buffer #(.WIDTH(`TX_WORD_W), .DEPTH(`BUF_DEPTH)) u_tx_buf (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .fill    (in_if.snk),
    .drain   (out_if.src)
  );

  pin_sync #(.WIDTH(`SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     ({ext_delay_ready, phy_rx_clk, phy_rx_dv, phy_rx_er, phy_col, phy_crs, phy_rxd}),
    .level   (sy)
  );

  // one word taken per reference period, at its rising phase
  assign out_if.ready = (phase_reg == `TX_PH_RISE);
  assign tx_ref       = (phase_reg < `TX_PH_MID);
  assign phase_shift  = tx_phase_t'(phase_reg - `TX_PH_QUAD);
  assign tx_ref_q     = (phase_shift < `TX_PH_MID);
  assign ref_cat      = {ref_line_reg, tx_ref};

  always_comb begin
    phase_next    = tx_phase_t'(phase_reg + 1'b1);
    ref_line_next = ref_cat[`OUT_DELAY_CYC-1:0];
    tx_word_next  = tx_word_reg;
    tx_act_next   = tx_act_reg;
    txd_next      = phy_txd;
    tx_en_next    = phy_tx_en;
    tx_er_next    = phy_tx_er;
    if (phase_reg == `TX_PH_RISE) begin
      tx_act_next  = out_if.valid;
      tx_word_next = out_if.valid ? out_if.data : '0;
    end
    if (!mode_reduced) begin
      tx_clk_next = ~tx_ref;
      if (phase_reg == `TX_PH_RISE) begin
        txd_next   = tx_word_next[7:0];
        tx_en_next = tx_act_next;
        tx_er_next = tx_act_next & tx_word_next[`TX_ERR_BIT];
      end
    end else begin
      // quadrature copy only ever reaches the clock pin
      tx_clk_next = has_out_delay ? ref_line_reg[`OUT_DELAY_CYC-1] : tx_ref_q;
      tx_er_next  = 1'b0;
      if (phase_reg == `TX_PH_RISE) begin
        txd_next   = {`NIB_ZERO, tx_word_next[3:0]};
        tx_en_next = tx_act_next;
      end else if (phase_reg == `TX_PH_MID) begin
        txd_next   = {`NIB_ZERO, tx_word_reg[7:4]};
        tx_en_next = tx_act_reg ^ (tx_act_reg & tx_word_reg[`TX_ERR_BIT]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase_reg    <= `TX_PH_RISE;
      ref_line_reg <= '0;
      tx_word_reg  <= '0;
      tx_act_reg   <= 1'b0;
      phy_txd      <= `BYTE_ZERO;
      phy_tx_en    <= 1'b0;
      phy_tx_er    <= 1'b0;
      phy_tx_clk   <= 1'b0;
    end else begin
      phase_reg    <= phase_next;
      ref_line_reg <= ref_line_next;
      tx_word_reg  <= tx_word_next;
      tx_act_reg   <= tx_act_next;
      phy_txd      <= txd_next;
      phy_tx_en    <= tx_en_next;
      phy_tx_er    <= tx_er_next;
      phy_tx_clk   <= tx_clk_next;
    end
  end

  // calibration runs in every instance; its result is used only where this instance owns the shared logic
  always_comb begin
    cal_state_next = cal_state_reg;
    cal_cnt_next   = cal_cnt_reg;
    unique case (cal_state_reg)
      CAL_BUSY: begin
        if (cal_cnt_reg == `CAL_CNT_W'(`CAL_CYC - 1)) begin
          cal_state_next = CAL_DONE;
        end else begin
          cal_cnt_next = `CAL_CNT_W'(cal_cnt_reg + 1'b1);
        end
      end
      CAL_DONE: begin
        cal_cnt_next = cal_cnt_reg;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cal_state_reg <= CAL_BUSY;
      cal_cnt_reg   <= '0;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_cnt_reg   <= cal_cnt_next;
    end
  end

  assign delay_ready = SHARED_LOGIC ? (cal_state_reg == CAL_DONE) : sy[`SY_XRDY];
  assign col_sync    = sy[`SY_COL];
  assign crs_sync    = sy[`SY_CRS];

  // rx edges found on the settled clock level, own clock per instance
  assign rx_rise  = sy[`SY_CLK] & ~rx_clk_prev_reg;
  assign rx_fall  = ~sy[`SY_CLK] & rx_clk_prev_reg;
  assign rise_dly = rise_line_reg[rx_delay_taps];
  assign fall_dly = fall_line_reg[rx_delay_taps];

  always_comb begin
    rise_line_next = {rise_line_reg[`TAP_N-2:0], rx_rise};
    fall_line_next = {fall_line_reg[`TAP_N-2:0], rx_fall};
    rx_data_next   = rx_data_reg;
    rx_err_next    = rx_err_reg;
    rx_valid_next  = 1'b0;
    lo_nib_next    = lo_nib_reg;
    lo_ctl_next    = lo_ctl_reg;
    // nothing captured until the delay taps are calibrated
    if (delay_ready) begin
      if (!mode_reduced) begin
        if (rise_dly) begin
          rx_data_next  = sy[7:0];
          rx_valid_next = sy[`SY_DV];
          rx_err_next   = sy[`SY_ER];
        end
      end else begin
        if (rise_dly) begin
          lo_nib_next = sy[3:0];
          lo_ctl_next = sy[`SY_DV];
        end
        if (fall_dly) begin
          rx_data_next  = {sy[3:0], lo_nib_reg};
          rx_valid_next = lo_ctl_reg;
          rx_err_next   = lo_ctl_reg ^ sy[`SY_DV];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_clk_prev_reg <= 1'b0;
      rise_line_reg   <= '0;
      fall_line_reg   <= '0;
      rx_data_reg     <= `BYTE_ZERO;
      rx_valid_reg    <= 1'b0;
      rx_err_reg      <= 1'b0;
      lo_nib_reg      <= `NIB_ZERO;
      lo_ctl_reg      <= 1'b0;
    end else begin
      rx_clk_prev_reg <= sy[`SY_CLK];
      rise_line_reg   <= rise_line_next;
      fall_line_reg   <= fall_line_next;
      rx_data_reg     <= rx_data_next;
      rx_valid_reg    <= rx_valid_next;
      rx_err_reg      <= rx_err_next;
      lo_nib_reg      <= lo_nib_next;
      lo_ctl_reg      <= lo_ctl_next;
    end
  end

  assign rx_data  = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign rx_err   = rx_err_reg;

  // checks, mode pins assumed static while they apply
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_fwd_clk_inverted;
    (!mode_reduced && $stable(mode_reduced) && phase_reg == `TX_PH_MID) |=> $rose(phy_tx_clk);
  endproperty
  a_fwd_clk_inverted: assert property (p_fwd_clk_inverted)
    else $error("byte-wide forwarded clock not rising mid period");

  property p_txd_from_rise;
    (!mode_reduced && $stable(mode_reduced) && $changed(phy_txd)) |-> $past(phase_reg) == `TX_PH_RISE;
  endproperty
  a_txd_from_rise: assert property (p_txd_from_rise)
    else $error("byte-wide tx data changed off the rising phase");

  property p_high_nibble;
    (mode_reduced && $stable(mode_reduced) && phase_reg == `TX_PH_MID)
      |=> phy_txd[3:0] == $past(tx_word_reg[7:4]);
  endproperty
  a_high_nibble: assert property (p_high_nibble)
    else $error("reduced tx high nibble not sent at mid period");

  property p_quad_clock;
    (mode_reduced && !has_out_delay && phase_reg == `TX_PH_QUAD) |=> $rose(phy_tx_clk);
  endproperty
  a_quad_clock: assert property (p_quad_clock)
    else $error("quadrature forwarded clock edge misplaced");

  property p_delayed_clock;
    (mode_reduced && has_out_delay && $stable(has_out_delay) && phase_reg == `TX_PH_RISE)
      |-> ##2 $rose(phy_tx_clk);
  endproperty
  a_delayed_clock: assert property (p_delayed_clock)
    else $error("delayed forwarded clock does not lag the data");

  property p_col_sync;
    $rose(phy_col) ##1 phy_col [*4] |-> col_sync;
  endproperty
  a_col_sync: assert property (p_col_sync)
    else $error("collision input not passed after synchroniser");

  property p_rx_needs_cal;
    rx_valid |-> delay_ready;
  endproperty
  a_rx_needs_cal: assert property (p_rx_needs_cal)
    else $error("rx byte captured before delay calibration");

  property p_rx_rise_capture;
    (!mode_reduced && delay_ready && rise_dly) |=> rx_valid == $past(sy[`SY_DV]);
  endproperty
  a_rx_rise_capture: assert property (p_rx_rise_capture)
    else $error("byte-wide rx valid not taken at delayed rise");

  property p_rx_low_nibble;
    (mode_reduced && delay_ready && fall_dly && !rise_dly) |=> rx_data[3:0] == $past(lo_nib_reg);
  endproperty
  a_rx_low_nibble: assert property (p_rx_low_nibble)
    else $error("reduced rx byte lost its low nibble");

  c_tx_sent: cover property (phy_tx_en && !mode_reduced);
  c_rx_reduced: cover property (rx_valid && mode_reduced);
  c_buf_full: cover property (tx_valid && !tx_ready);
endmodule // gphy_port

// ===== gphy_port_map.svh
// constants for the gigabit phy port: clock phases, delays, pin bit slots
// assumes a 200 MHz system clock; included by bare name
`ifndef GPHY_PORT_MAP_SVH
`define GPHY_PORT_MAP_SVH

`define SYS_CLK_PS      5000
`define TX_PH_RISE      3'h0
`define TX_PH_QUAD      3'h2
`define TX_PH_MID       3'h4
`define TX_PH_LAST      3'h7
`define OUT_DELAY_PS    2000
`define OUT_DELAY_CYC   (((`OUT_DELAY_PS) + (`SYS_CLK_PS) - 1) / (`SYS_CLK_PS))
`define CAL_TIME_PS     100000
`define CAL_CYC         (((`CAL_TIME_PS) + (`SYS_CLK_PS) - 1) / (`SYS_CLK_PS))
`define CAL_CNT_W       5
`define TAP_N           8
`define BUF_DEPTH       2
`define TX_WORD_W       9
`define TX_ERR_BIT      8
`define SYNC_W          14
`define SY_XRDY         13
`define SY_CLK          12
`define SY_DV           11
`define SY_ER           10
`define SY_COL          9
`define SY_CRS          8
`define NIB_ZERO        4'h0
`define BYTE_ZERO       8'h00

`endif

// ===== phy_partner.sv
// phy partner: drives rx pins and line state, captures tx pins on the forwarded clock
// assumes a 64 ns rx clock that runs only inside frames and idles low
`timescale 1ns/10ps
module phy_partner (
  input  wire logic            mode_reduced,
  input  wire logic            phy_tx_clk,
  input  wire gphy_pkg::byte_t phy_txd,
  input  wire logic            phy_tx_en,
  input  wire logic            phy_tx_er,
  output gphy_pkg::byte_t      phy_rxd,
  output logic                 phy_rx_dv,
  output logic                 phy_rx_er,
  output logic                 phy_rx_clk,
  output logic                 phy_col,
  output logic                 phy_crs
);
  import gphy_pkg::*;
  logic [9:0] tx_q[$];
  byte_t      lo_txd;
  logic       lo_en;
  logic       lo_bad;

  initial begin
    phy_rxd    = 8'h5A;
    phy_rx_dv  = 1'b0;
    phy_rx_er  = 1'b0;
    phy_rx_clk = 1'b0;
    phy_col    = 1'b0;
    phy_crs    = 1'b0;
  end

  // sampled on the forwarded clock only, as a real phy would
  always @(posedge phy_tx_clk) begin
    lo_txd = phy_txd;
    lo_en  = phy_tx_en;
    lo_bad = (phy_txd[7:4] !== 4'h0) || (phy_tx_er !== 1'b0);
    if (!mode_reduced && phy_tx_en) tx_q.push_back({1'b0, phy_tx_er, phy_txd});
  end

  // second half of a reduced byte; ctl on the fall is en xor err
  always @(negedge phy_tx_clk) begin
    if (mode_reduced && (lo_en || phy_tx_en)) begin
      tx_q.push_back({lo_bad || (phy_txd[7:4] !== 4'h0), lo_en ^ phy_tx_en,
                      phy_txd[3:0], lo_txd[3:0]});
    end
  end

  // data moves 20 ns after each edge, so both edges see settled pins
  task automatic rx_byte(input byte_t b, input logic er);
    phy_rx_dv = 1'b1;
    phy_rx_er = mode_reduced ? ~er : er;
    phy_rxd   = mode_reduced ? {~b[3:0], b[3:0]} : b;
    #12 phy_rx_clk = 1'b1;
    #20;
    if (mode_reduced) begin
      phy_rxd   = {~b[7:4], b[7:4]};
      phy_rx_dv = ~er;
    end
    #12 phy_rx_clk = 1'b0;
    #20;
  endtask

  // idle: clock stands still, data lines no longer hold the last value
  task automatic rx_idle();
    phy_rx_dv = 1'b0;
    phy_rx_er = 1'b0;
    phy_rxd   = ~phy_rxd;
  endtask

  task automatic line_state(input logic col, input logic crs);
    phy_col = col;
    phy_crs = crs;
  endtask
endmodule // phy_partner

// ===== pin_sync.sv
// three-stage synchroniser per bit, output follows once stages two and three agree
// assumes inputs asynchronous to sys_clk
`timescale 1ns/10ps
module pin_sync #(parameter int WIDTH = 1) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
      always_comb begin
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      end
      // first stage feeds only the second
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg  <= pin[i];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          lvl_reg <= lvl_next;
        end
      end
      assign level[i] = lvl_reg;
    end
  endgenerate
endmodule // pin_sync

// ===== stream_if.sv
// valid/ready word carrier between the port modules
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 9);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // stream_if

// ===== tb_gigabit_phy_port_clocking.sv
// self-checking bench for gphy_port: random tx and rx traffic in all three link modes
// assumes phy_partner on the pins and a 200 MHz system clock
`timescale 1ns/10ps
module tb_gigabit_phy_port_clocking;
  import gphy_pkg::*;
  logic        sys_clk, nrst, mode_reduced, has_out_delay, ext_delay_ready;
  logic        tx_err, tx_valid, tx_ready, rx_valid, rx_err, col_sync, crs_sync;
  logic        delay_ready, phy_tx_en, phy_tx_er, phy_tx_clk;
  logic        phy_rx_dv, phy_rx_er, phy_rx_clk, phy_col, phy_crs;
  logic        ext_ready, ext_tx_clk;
  tap_sel_t    rx_delay_taps;
  byte_t       tx_data, rx_data, phy_txd, phy_rxd;
  int          mismatches = 0;
  int          n_checks = 0;
  int          en_age = 0;
  logic [31:0] seed = 32'h00014584;
  logic [8:0]  exp_q[$];
  logic [8:0]  rx_got[$];
  logic        saw_full = 1'b0, en_prev = 1'b0, clk_prev = 1'b0, lag_armed = 1'b0;

  gphy_port #(.SHARED_LOGIC(1'b1)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .mode_reduced(mode_reduced),
    .has_out_delay(has_out_delay), .rx_delay_taps(rx_delay_taps),
    .ext_delay_ready(ext_delay_ready), .tx_data(tx_data), .tx_err(tx_err),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .col_sync(col_sync), .crs_sync(crs_sync), .delay_ready(delay_ready),
    .phy_txd(phy_txd), .phy_tx_en(phy_tx_en), .phy_tx_er(phy_tx_er),
    .phy_tx_clk(phy_tx_clk), .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv),
    .phy_rx_er(phy_rx_er), .phy_rx_clk(phy_rx_clk), .phy_col(phy_col), .phy_crs(phy_crs)
  );

  // second port without shared logic: readiness from outside, same tx reference
  gphy_port #(.SHARED_LOGIC(1'b0)) u_dut_ext (
    .sys_clk(sys_clk), .nrst(nrst), .mode_reduced(mode_reduced),
    .has_out_delay(has_out_delay), .rx_delay_taps(rx_delay_taps),
    .ext_delay_ready(ext_delay_ready), .tx_data(tx_data), .tx_err(tx_err),
    .tx_valid(1'b0), .tx_ready(), .rx_data(), .rx_valid(), .rx_err(), .col_sync(),
    .crs_sync(), .delay_ready(ext_ready), .phy_txd(), .phy_tx_en(), .phy_tx_er(),
    .phy_tx_clk(ext_tx_clk), .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv),
    .phy_rx_er(phy_rx_er), .phy_rx_clk(phy_rx_clk), .phy_col(phy_col), .phy_crs(phy_crs)
  );

  phy_partner u_phy (
    .mode_reduced(mode_reduced), .phy_tx_clk(phy_tx_clk), .phy_txd(phy_txd),
    .phy_tx_en(phy_tx_en), .phy_tx_er(phy_tx_er), .phy_rxd(phy_rxd),
    .phy_rx_dv(phy_rx_dv), .phy_rx_er(phy_rx_er), .phy_rx_clk(phy_rx_clk),
    .phy_col(phy_col), .phy_crs(phy_crs)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // phy view of a word: illegal-pin flag clear, then err and byte
  function automatic logic [9:0] tx_expect(input logic [8:0] w);
    return {1'b0, w};
  endfunction

  // cycles from tx enable rising to the forwarded clock rising
  function automatic int clk_lag(input logic red, input logic dly);
    return !red ? 4 : (dly ? 1 : 2);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // sampled mid-cycle so every registered output has settled
  always @(negedge sys_clk) begin
    if (tx_valid && tx_ready === 1'b0) saw_full = 1'b1;
    en_age = en_age + 1;
    if (phy_tx_clk === 1'b1 && !clk_prev && lag_armed) begin
      check("clock lag", en_age, clk_lag(mode_reduced, has_out_delay));
      lag_armed = 1'b0;
    end
    if (phy_tx_en === 1'b1 && !en_prev) begin
      en_age    = 0;
      lag_armed = 1'b1;
    end
    en_prev  = phy_tx_en;
    clk_prev = phy_tx_clk;
    if (rx_valid === 1'b1) rx_got.push_back({rx_err, rx_data});
  end

  // mode pins only change under reset; one rx byte is sent while calibrating
  task automatic do_reset(input logic red, input logic dly);
    int n;
    n = 0;
    @(posedge sys_clk);
    seed = lfsr(seed);
    nrst          <= 1'b0;
    mode_reduced  <= red;
    has_out_delay <= dly;
    rx_delay_taps <= {2'b00, seed[0]};
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rx_got.delete();
    fork
      while (delay_ready !== 1'b1 && n < 40) begin
        @(negedge sys_clk);
        n++;
      end
      u_phy.rx_byte(seed[8:1], 1'b0);
    join
    u_phy.rx_idle();
    check("ready delay", (n >= 19 && n <= 21), 1'b1);
    check("early rx", rx_got.size(), 0);
  endtask

  // back to back words fill the two-entry buffer; corner words first
  task automatic tx_burst(input int n);
    logic [8:0] w;
    saw_full = 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      w = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : seed[8:0];
      exp_q.push_back(w);
      tx_data  <= w[7:0];
      tx_err   <= w[8];
      tx_valid <= 1'b1;
      @(posedge sys_clk);
      while (tx_ready !== 1'b1) @(posedge sys_clk);
    end
    tx_valid <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check("buffer full", saw_full, 1'b1);
    check("tx count", u_phy.tx_q.size(), n);
    while (exp_q.size() > 0 && u_phy.tx_q.size() > 0) begin
      check("tx word", u_phy.tx_q.pop_front(), tx_expect(exp_q.pop_front()));
    end
    exp_q.delete();
  endtask

  task automatic rx_burst(input int n);
    logic [8:0] w;
    rx_got.delete();
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      w = (i == 0) ? 9'h1A5 : seed[8:0];
      exp_q.push_back(w);
      u_phy.rx_byte(w[7:0], w[8]);
    end
    u_phy.rx_idle();
    repeat (30) @(posedge sys_clk);
    check("rx count", rx_got.size(), n);
    while (exp_q.size() > 0 && rx_got.size() > 0) begin
      check("rx word", rx_got.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
  endtask

  initial begin
    logic c, s, cp, sp;
    nrst            = 1'b0;
    mode_reduced    = 1'b0;
    has_out_delay   = 1'b0;
    rx_delay_taps   = 3'h0;
    ext_delay_ready = 1'b0;
    tx_data         = 8'h00;
    tx_err          = 1'b0;
    tx_valid        = 1'b0;
    for (int m = 0; m < 3; m++) begin
      do_reset(m != 0, m == 2);
      tx_burst(12);
      rx_burst(10);
    end
    // the port without shared logic waits for the outside readiness pin
    @(negedge sys_clk);
    check("ext ready early", ext_ready, 1'b0);
    @(posedge sys_clk);
    ext_delay_ready <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check("ext ready sync", ext_ready, 1'b0);
    repeat (4) @(negedge sys_clk);
    check("ext ready", ext_ready, 1'b1);
    check("shared tx clock", ext_tx_clk, phy_tx_clk);
    cp = 1'b0;
    sp = 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      {c, s} = seed[1:0];
      @(negedge sys_clk);
      u_phy.line_state(c, s);
      repeat (2) @(negedge sys_clk);
      check("col early", col_sync, cp);
      check("crs early", crs_sync, sp);
      repeat (8) @(negedge sys_clk);
      check("col level", col_sync, c);
      check("crs level", crs_sync, s);
      cp = c;
      sp = s;
    end
    conclude();
  end

  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule // tb_gigabit_phy_port_clocking

// ===== word_buffer.sv
// small fifo of registered words with valid/ready on both sides
// assumes DEPTH is a power of two; both sides on sys_clk
`timescale 1ns/10ps
module word_buffer #(parameter int WIDTH = 9, parameter int DEPTH = 2) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  stream_if.snk     fill,
  stream_if.src     drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign fill.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign drain.valid = (cnt_reg != '0);
  assign drain.data  = mem_reg[rd_reg];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_comb begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = (AW+1)'(cnt_reg + push - pop);
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset, count guards it
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= fill.data;
    end
  end
endmodule // word_buffer
